// ==== inc/cpus_dgl_if.sv ====
// carrier between the sequencer and its deglitch filters
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface cpus_dgl_if;
   logic raw;
   logic tick;
   logic qual;
   modport owner (output raw, output tick, input qual);
   modport filt (input raw, input tick, output qual);
endinterface : cpus_dgl_if
`default_nettype wire

// ==== inc/cpus_params.svh ====
// constants of the charger power-up sequencer: times, limits, reset values
// assumes a 100 MHz system clock; included by bare name
`ifndef CPUS_PARAMS_SVH
`define CPUS_PARAMS_SVH

`define CPUS_CLK_KHZ 100000
`define CPUS_VBUS_OV_NS 200
`define CPUS_BAT_OV_DGL_NS 1000
`define CPUS_BAD_SRC_MS 30
`define CPUS_BIAS_HOLD_MS 220
`define CPUS_TERM_DGL_MS 250
`define CPUS_RECH_DGL_MS 250
`define CPUS_LPDIG_KHZ 30
`define CPUS_DIG_KHZ 1500
`define CPUS_MAX_FAIL 7
`define CPUS_SAFETY_MS 59400000
`define CPUS_TOPOFF_MS 2040000
`define CPUS_WDT_MS 164000
`define CPUS_SAFETY_SEL_00_MS 18000000
`define CPUS_SAFETY_SEL_01_MS 36000000
`define CPUS_SAFETY_SEL_11_MS 72000000
`define CPUS_TOPOFF_SEL_01_MS 900000
`define CPUS_TOPOFF_SEL_11_MS 2700000
`define CPUS_WDT_SEL_01_MS 40000
`define CPUS_WDT_SEL_10_MS 80000
`define CPUS_ILIM_RST 5'h04
`define CPUS_SYNC_VBUS 0
`define CPUS_SYNC_BAT 1
`define CPUS_SYNC_OV 2
`define CPUS_SYNC_LOW 3
`define CPUS_SYNC_TERM 4
`define CPUS_SYNC_RECH 5
`define CPUS_SYNC_BATOV 6
`define CPUS_SYNC_W 7

`endif

// ==== inc/cpus_pkg.sv ====
// types of the charger power-up sequencer
// assumes nothing beyond the tool's package support
package cpus_pkg;

   // gray codes along idle, qualify, detect, bias wait, run
   typedef enum logic [2:0]
   {
      CPUS_IDLE = 3'h0,
      CPUS_QUAL = 3'h1,
      CPUS_DET = 3'h3,
      CPUS_BIAS = 3'h2,
      CPUS_RUN = 3'h6,
      CPUS_HIZ = 3'h7,
      CPUS_OVW = 3'h5
   } cpus_state_t;

   typedef struct packed
   {
      logic [31:0] cnt;
      logic qual;
   } cpus_dgl_t;

endpackage : cpus_pkg

// ==== logic/cpus_deglitch.sv ====
// deglitch filter: qualifies a level that holds for COUNT ticks
// assumes raw already synchronised to clk_sys
`timescale 1ns/1ns
`default_nettype none
module cpus_deglitch #(
   parameter int COUNT = 250
) (
   input wire logic clk_sys,
   input wire logic rstn,
   cpus_dgl_if.filt dgl
);
   if (COUNT < 1)
   begin : g_bad_count
      $error("cpus_deglitch: COUNT must be at least 1");
   end

   cpus_pkg::cpus_dgl_t s_reg;
   cpus_pkg::cpus_dgl_t s_next;

   // ****************************
   // filter
   // ****************************
   always_comb
   begin
      s_next = s_reg;
      if (!dgl.raw)
      begin
         // any drop restarts the window
         s_next.cnt = 32'h0;
         s_next.qual = 1'b0;
      end
      else if (dgl.tick && !s_reg.qual)
      begin
         s_next.cnt = s_reg.cnt + 32'h1;
         s_next.qual = (s_reg.cnt + 32'h1) >= 32'(COUNT);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign dgl.qual = s_reg.qual;

   property p_dgl_cause;
      @(posedge clk_sys) disable iff (!rstn)
      $rose(s_reg.qual) |-> $past(dgl.raw) && s_reg.cnt == 32'(COUNT);
   endproperty
   a_dgl_cause : assert property (p_dgl_cause) else $error("deglitch qualified early");

   property p_dgl_drop;
      @(posedge clk_sys) disable iff (!rstn)
      !dgl.raw |=> !s_reg.qual;
   endproperty
   a_dgl_drop : assert property (p_dgl_drop) else $error("deglitch held after drop");

endmodule : cpus_deglitch
`default_nettype wire

// ==== logic/cpus_sequencer.sv ====
// charger power-up sequencer: reset, qualification, start order, timers
// assumes analog comparator levels on pins, host bits on same clock
`timescale 1ns/1ns
`default_nettype none
`include "cpus_params.svh"
// What this block does
// - supply above undervoltage: reset, battery switch driver
// - reset restores defaults, then host port ready
// - battery only: switch closed, bias regulator off
// - battery only: discharge current monitored continuously
// - qualify, detect, bias regulator, converter, in order
// - detection result loads input current limit
// - qualify: no overvoltage, above bad level 30ms
// - overvoltage cleared restarts qualification automatically
// - retry bad source; seventh failure enters disconnect
// - leave disconnect on reattach or host toggle
// - adapter attach clears disconnect request bit
// - overvoltage switches converter off within 200ns
// - termination after 250ms below termination level
// - recharge after 250ms below recharge level
// - battery overvoltage 1us stops charging
// - safety timer 16.5 hours at selection 10
// - top-off 34 minutes at selection 10
// - watchdog 164 seconds at selection 11
// - logic tick 30kHz off, 1.5MHz regulator on
// - bias regulator after conditions hold 220ms
module cpus_sequencer #(
   parameter int MS_CYCLES = 100000,
   parameter int SAFETY_MS = `CPUS_SAFETY_MS,
   parameter int TOPOFF_MS = `CPUS_TOPOFF_MS,
   parameter int WDT_MS = `CPUS_WDT_MS
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic vbus_above_uvlo,
   input wire logic bat_above_uvlo,
   input wire logic vbus_over_volt,
   input wire logic vbus_below_bad_src,
   input wire logic chg_below_term,
   input wire logic bat_below_rech,
   input wire logic bat_over_volt,
   input wire logic det_done,
   input wire logic [4:0] det_ilim,
   input wire logic charge_en,
   input wire logic disconnect_wr,
   input wire logic disconnect_wdata,
   input wire logic host_service,
   input wire logic [1:0] charge_time_limit_sel,
   input wire logic [1:0] finish_charge_time_sel,
   input wire logic [1:0] watchdog_sel,
   output logic por_rst,
   output logic i2c_ready,
   output logic battery_switch_drv_en,
   output logic battery_switch,
   output logic discharge_monitor_en,
   output logic internal_bias_regulator,
   output logic bad_src_sink_en,
   output logic det_start,
   output logic converter_en,
   output logic [4:0] input_current_limit_field,
   output logic input_disconnect_request,
   output logic hiz,
   output logic [2:0] fail_count,
   output logic charging,
   output logic charge_done,
   output logic recharge_req,
   output logic bat_ovp_stop,
   output logic safety_expired,
   output logic topoff_active,
   output logic watchdog_expired,
   output logic dig_tick
);
   localparam int OV_CYC = (`CPUS_VBUS_OV_NS * (`CPUS_CLK_KHZ / 1000)) / 1000;
   localparam int BATOV_CYC = (`CPUS_BAT_OV_DGL_NS * (`CPUS_CLK_KHZ / 1000) + 999) / 1000;
   localparam int LPDIG_DIV = `CPUS_CLK_KHZ / `CPUS_LPDIG_KHZ;
   localparam int DIG_DIV = `CPUS_CLK_KHZ / `CPUS_DIG_KHZ;

   if (MS_CYCLES < 1 || SAFETY_MS < 1 || TOPOFF_MS < 1 || WDT_MS < 1 || OV_CYC < 4)
   begin : g_bad_param
      $error("cpus_sequencer: counts too small for the logic");
   end

   typedef struct packed
   {
      logic [`CPUS_SYNC_W-1:0] sync1;
      logic [`CPUS_SYNC_W-1:0] sync2;
      logic power_seen;
      logic por_pulse;
      logic i2c_ready;
      cpus_pkg::cpus_state_t st;
      logic [2:0] fail_cnt;
      logic vbus_prev;
      logic low_seen;
      logic [15:0] win_cnt;
      logic [31:0] ms_cnt;
      logic ms_tick;
      logic [11:0] dig_cnt;
      logic dig_tick;
      logic disc;
      logic [4:0] ilim;
      logic conv_en;
      logic bias_en;
      logic sink_en;
      logic det_start;
      logic done;
      logic [31:0] safety_cnt;
      logic safety_exp;
      logic [31:0] topoff_cnt;
      logic topoff_on;
      logic [31:0] wdt_cnt;
      logic wdt_exp;
   } cpus_top_t;

   cpus_top_t s_reg;
   cpus_top_t s_next;

   // ****************************
   // selection decoding
   // ****************************
   function automatic logic [31:0] safety_limit(input logic [1:0] sel);
      case (sel)
         2'h0: safety_limit = `CPUS_SAFETY_SEL_00_MS;
         2'h1: safety_limit = `CPUS_SAFETY_SEL_01_MS;
         2'h2: safety_limit = 32'(SAFETY_MS);
         default: safety_limit = `CPUS_SAFETY_SEL_11_MS;
      endcase
   endfunction : safety_limit

   // zero means the timer is disabled
   function automatic logic [31:0] topoff_limit(input logic [1:0] sel);
      case (sel)
         2'h1: topoff_limit = `CPUS_TOPOFF_SEL_01_MS;
         2'h2: topoff_limit = 32'(TOPOFF_MS);
         2'h3: topoff_limit = `CPUS_TOPOFF_SEL_11_MS;
         default: topoff_limit = 32'h0;
      endcase
   endfunction : topoff_limit

   function automatic logic [31:0] wdt_limit(input logic [1:0] sel);
      case (sel)
         2'h1: wdt_limit = `CPUS_WDT_SEL_01_MS;
         2'h2: wdt_limit = `CPUS_WDT_SEL_10_MS;
         2'h3: wdt_limit = 32'(WDT_MS);
         default: wdt_limit = 32'h0;
      endcase
   endfunction : wdt_limit

   // ****************************
   // deglitch filters: termination, recharge, battery overvoltage
   // ****************************
   cpus_dgl_if dgl_if [3] ();
   logic [2:0] dgl_raw;
   logic [2:0] dgl_tick;
   logic [2:0] dgl_qual;

   assign dgl_raw = {s_reg.sync2[`CPUS_SYNC_BATOV], s_reg.sync2[`CPUS_SYNC_RECH],
                     s_reg.sync2[`CPUS_SYNC_TERM]};
   // overvoltage filter counts system clocks, the others milliseconds
   assign dgl_tick = {1'b1, s_reg.ms_tick, s_reg.ms_tick};

   for (genvar i = 0; i < 3; i++)
   begin : g_dgl
      localparam int CNT = (i == 0) ? `CPUS_TERM_DGL_MS :
                           (i == 1) ? `CPUS_RECH_DGL_MS : BATOV_CYC;
      assign dgl_if[i].raw = dgl_raw[i];
      assign dgl_if[i].tick = dgl_tick[i];
      assign dgl_qual[i] = dgl_if[i].qual;
      cpus_deglitch #(.COUNT(CNT)) u_dgl (
         .clk_sys(clk_sys),
         .rstn(rstn),
         .dgl(dgl_if[i])
      );
   end

   // ****************************
   // next state
   // ****************************
   logic vbus_ok;
   logic power_ok;
   logic ov;
   logic attach;
   logic run_chg;
   logic [31:0] top_lim;
   logic [31:0] wdt_lim;

   assign vbus_ok = s_reg.sync2[`CPUS_SYNC_VBUS];
   assign power_ok = vbus_ok | s_reg.sync2[`CPUS_SYNC_BAT];
   assign ov = s_reg.sync2[`CPUS_SYNC_OV];
   // edge taken behind the second flop, the first one feeds nothing else
   assign attach = vbus_ok & ~s_reg.vbus_prev;
   assign top_lim = topoff_limit(finish_charge_time_sel);
   assign wdt_lim = wdt_limit(watchdog_sel);
   assign run_chg = s_reg.st == cpus_pkg::CPUS_RUN && charge_en && !dgl_qual[2] &&
                    !s_reg.safety_exp && (!s_reg.done || s_reg.topoff_on);

   always_comb
   begin
      s_next = s_reg;
      s_next.sync1 = {bat_over_volt, bat_below_rech, chg_below_term, vbus_below_bad_src,
                      vbus_over_volt, bat_above_uvlo, vbus_above_uvlo};
      s_next.sync2 = s_reg.sync1;
      s_next.vbus_prev = vbus_ok;
      s_next.por_pulse = 1'b0;
      s_next.ms_tick = 1'b0;
      s_next.dig_tick = 1'b0;
      // milliseconds base for all slow timers
      if (s_reg.ms_cnt >= 32'(MS_CYCLES - 1))
      begin
         s_next.ms_cnt = 32'h0;
         s_next.ms_tick = 1'b1;
      end
      else
         s_next.ms_cnt = s_reg.ms_cnt + 32'h1;
      if (s_reg.dig_cnt >= 12'((s_reg.bias_en ? DIG_DIV : LPDIG_DIV) - 1))
      begin
         s_next.dig_cnt = 12'h0;
         s_next.dig_tick = 1'b1;
      end
      else
         s_next.dig_cnt = s_reg.dig_cnt + 12'h1;
      if (!s_reg.power_seen && power_ok)
      begin
         s_next.power_seen = 1'b1;
         s_next.por_pulse = 1'b1;
      end
      s_next.i2c_ready = s_reg.power_seen;
      if (disconnect_wr)
         s_next.disc = disconnect_wdata;
      if (attach)
         s_next.disc = 1'b0;
      s_next.sink_en = 1'b0;
      s_next.det_start = 1'b0;
      if (s_reg.st != cpus_pkg::CPUS_QUAL)
         s_next.low_seen = 1'b0;
      case (s_reg.st)
         cpus_pkg::CPUS_IDLE:
         begin
            s_next.win_cnt = 16'h0;
            if (vbus_ok && !s_reg.disc)
               s_next.st = cpus_pkg::CPUS_QUAL;
         end
         cpus_pkg::CPUS_QUAL:
         begin
            s_next.sink_en = 1'b1;
            if (s_reg.sync2[`CPUS_SYNC_LOW])
               s_next.low_seen = 1'b1;
            if (ov)
               s_next.st = cpus_pkg::CPUS_OVW;
            else if (s_reg.ms_tick)
            begin
               s_next.win_cnt = s_reg.win_cnt + 16'h1;
               if (s_reg.win_cnt == 16'(`CPUS_BAD_SRC_MS - 1))
               begin
                  s_next.win_cnt = 16'h0;
                  s_next.low_seen = 1'b0;
                  // one dip fails the whole window, so one retry per window
                  if (s_reg.low_seen || s_reg.sync2[`CPUS_SYNC_LOW])
                  begin
                     s_next.fail_cnt = s_reg.fail_cnt + 3'h1;
                     if (s_reg.fail_cnt == 3'(`CPUS_MAX_FAIL - 1))
                        s_next.st = cpus_pkg::CPUS_HIZ;
                  end
                  else
                  begin
                     s_next.fail_cnt = 3'h0;
                     s_next.st = cpus_pkg::CPUS_DET;
                  end
               end
            end
         end
         cpus_pkg::CPUS_DET:
         begin
            s_next.det_start = 1'b1;
            if (det_done)
            begin
               s_next.ilim = det_ilim;
               s_next.st = cpus_pkg::CPUS_BIAS;
            end
         end
         cpus_pkg::CPUS_BIAS:
         begin
            // detection result and input must hold the whole time
            if (!det_done)
               s_next.win_cnt = 16'h0;
            else if (s_reg.ms_tick)
            begin
               s_next.win_cnt = s_reg.win_cnt + 16'h1;
               if (s_reg.win_cnt == 16'(`CPUS_BIAS_HOLD_MS - 1))
                  s_next.st = cpus_pkg::CPUS_RUN;
            end
         end
         cpus_pkg::CPUS_RUN:
            s_next.win_cnt = 16'h0;
         cpus_pkg::CPUS_OVW:
         begin
            s_next.win_cnt = 16'h0;
            if (!ov)
               s_next.st = cpus_pkg::CPUS_QUAL;
         end
         cpus_pkg::CPUS_HIZ:
         begin
            s_next.win_cnt = 16'h0;
            // host toggle back to zero releases the fallback
            if (disconnect_wr && s_reg.disc && !disconnect_wdata)
            begin
               s_next.fail_cnt = 3'h0;
               s_next.st = cpus_pkg::CPUS_QUAL;
            end
         end
         default:
            s_next.st = cpus_pkg::CPUS_IDLE;
      endcase
      if (ov && s_reg.st != cpus_pkg::CPUS_QUAL && s_reg.st != cpus_pkg::CPUS_IDLE &&
          s_reg.st != cpus_pkg::CPUS_HIZ)
         s_next.st = cpus_pkg::CPUS_OVW;
      if (s_next.disc && s_reg.st != cpus_pkg::CPUS_IDLE && !disconnect_wr)
         s_next.st = cpus_pkg::CPUS_HIZ;
      if (!vbus_ok)
      begin
         s_next.st = cpus_pkg::CPUS_IDLE;
         s_next.fail_cnt = 3'h0;
      end
      s_next.bias_en = s_next.st == cpus_pkg::CPUS_RUN;
      s_next.conv_en = s_next.st == cpus_pkg::CPUS_RUN && s_reg.bias_en;
      // ****************************
      // charge timers
      // ****************************
      if (dgl_qual[0] && run_chg)
         s_next.done = 1'b1;
      if (dgl_qual[1] || s_reg.st != cpus_pkg::CPUS_RUN)
         s_next.done = 1'b0;
      if (!charge_en || s_reg.st != cpus_pkg::CPUS_RUN)
      begin
         s_next.safety_cnt = 32'h0;
         s_next.safety_exp = 1'b0;
      end
      else if (run_chg && s_reg.ms_tick)
      begin
         s_next.safety_cnt = s_reg.safety_cnt + 32'h1;
         if (s_reg.safety_cnt + 32'h1 >= safety_limit(charge_time_limit_sel))
            s_next.safety_exp = 1'b1;
      end
      if (!s_reg.done)
      begin
         s_next.topoff_cnt = 32'h0;
         s_next.topoff_on = top_lim != 32'h0;
      end
      else if (s_reg.topoff_on && s_reg.ms_tick)
      begin
         s_next.topoff_cnt = s_reg.topoff_cnt + 32'h1;
         if (s_reg.topoff_cnt + 32'h1 >= top_lim)
            s_next.topoff_on = 1'b0;
      end
      if (host_service || wdt_lim == 32'h0)
      begin
         s_next.wdt_cnt = 32'h0;
         s_next.wdt_exp = 1'b0;
      end
      else if (s_reg.ms_tick && !s_reg.wdt_exp)
      begin
         s_next.wdt_cnt = s_reg.wdt_cnt + 32'h1;
         if (s_reg.wdt_cnt + 32'h1 >= wdt_lim)
            s_next.wdt_exp = 1'b1;
      end
      // without any supply every register but the synchronisers and the deglitch filters goes back to default
      if (!power_ok)
      begin
         s_next = '0;
         // pins keep being sampled, or power could never be seen again
         s_next.sync1 = {bat_over_volt, bat_below_rech, chg_below_term, vbus_below_bad_src,
                         vbus_over_volt, bat_above_uvlo, vbus_above_uvlo};
         s_next.sync2 = s_reg.sync1;
         s_next.ilim = `CPUS_ILIM_RST;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_reg <= '0;
         s_reg.ilim <= `CPUS_ILIM_RST;
      end
      else
         s_reg <= s_next;
   end

   // ****************************
   // outputs
   // ****************************
   assign por_rst = s_reg.por_pulse;
   assign i2c_ready = s_reg.i2c_ready;
   assign battery_switch_drv_en = s_reg.power_seen;
   assign battery_switch = s_reg.power_seen && s_reg.sync2[`CPUS_SYNC_BAT];
   assign discharge_monitor_en = battery_switch;
   assign internal_bias_regulator = s_reg.bias_en;
   assign bad_src_sink_en = s_reg.sink_en;
   assign det_start = s_reg.det_start;
   assign converter_en = s_reg.conv_en;
   assign input_current_limit_field = s_reg.ilim;
   assign input_disconnect_request = s_reg.disc;
   assign hiz = s_reg.st == cpus_pkg::CPUS_HIZ;
   assign fail_count = s_reg.fail_cnt;
   assign charging = run_chg;
   assign charge_done = s_reg.done;
   assign recharge_req = dgl_qual[1];
   assign bat_ovp_stop = dgl_qual[2];
   assign safety_expired = s_reg.safety_exp;
   assign topoff_active = s_reg.done && s_reg.topoff_on;
   assign watchdog_expired = s_reg.wdt_exp;
   assign dig_tick = s_reg.dig_tick;

   // ****************************
   // checks
   // ****************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_por;
      $rose(s_reg.power_seen) |-> por_rst ##1 i2c_ready;
   endproperty
   a_por : assert property (p_por) else $error("no reset pulse before ready");

   property p_bat_only;
      s_reg.sync2[`CPUS_SYNC_BAT] && !vbus_ok && s_reg.power_seen |=>
         !internal_bias_regulator && discharge_monitor_en;
   endproperty
   a_bat_only : assert property (p_bat_only) else $error("battery only misbehaves");

   property p_order;
      converter_en |-> internal_bias_regulator && $past(internal_bias_regulator);
   endproperty
   a_order : assert property (p_order) else $error("converter before regulator");

   property p_ilim;
      s_reg.st == cpus_pkg::CPUS_DET && det_done && power_ok |=>
         input_current_limit_field == $past(det_ilim);
   endproperty
   a_ilim : assert property (p_ilim) else $error("limit not loaded");

   property p_sink;
      s_reg.st == cpus_pkg::CPUS_QUAL && s_reg.win_cnt != 16'h0 |-> bad_src_sink_en;
   endproperty
   a_sink : assert property (p_sink) else $error("no sink during window");

   sequence s_last_fail;
      s_reg.st == cpus_pkg::CPUS_QUAL && s_reg.fail_cnt == 3'(`CPUS_MAX_FAIL - 1) &&
         s_reg.ms_tick && s_reg.win_cnt == 16'(`CPUS_BAD_SRC_MS - 1) &&
         (s_reg.low_seen || s_reg.sync2[`CPUS_SYNC_LOW]) && !ov && vbus_ok && !disconnect_wr;
   endsequence
   sequence s_in_hiz;
      hiz && fail_count == 3'h7;
   endsequence
   property p_hiz7;
      s_last_fail |=> s_in_hiz;
   endproperty
   a_hiz7 : assert property (p_hiz7) else $error("seventh failure not fallback");

   property p_attach;
      attach && power_ok |=> !input_disconnect_request;
   endproperty
   a_attach : assert property (p_attach) else $error("attach kept disconnect");

   property p_ovp;
      $rose(vbus_over_volt) ##1 vbus_over_volt [*2] |-> ##[0:3] !converter_en;
   endproperty
   a_ovp : assert property (p_ovp) else $error("converter on after overvoltage");

   property p_bias_hold;
      $rose(internal_bias_regulator) |-> $past(s_reg.st) == cpus_pkg::CPUS_BIAS &&
         $past(s_reg.win_cnt) == 16'(`CPUS_BIAS_HOLD_MS - 1);
   endproperty
   a_bias_hold : assert property (p_bias_hold) else $error("regulator without hold");

   property p_fail_clr;
      !vbus_ok |=> fail_count == 3'h0;
   endproperty
   a_fail_clr : assert property (p_fail_clr) else $error("count kept on removal");

   property p_batovp;
      bat_ovp_stop |-> !charging;
   endproperty
   a_batovp : assert property (p_batovp) else $error("charging under overvoltage");

   property p_wdt;
      $rose(watchdog_expired) |-> !$past(host_service) && $past(s_reg.ms_tick);
   endproperty
   a_wdt : assert property (p_wdt) else $error("watchdog fired while serviced");

endmodule : cpus_sequencer
`default_nettype wire

// ==== verification/charger_power_up_sequencer_bench.sv ====
// bench of the power-up sequencer with scaled millisecond counts
// assumes MS_CYCLES of 10, so one ms is ten clocks
`timescale 1ns/1ns
`default_nettype none
module charger_power_up_sequencer_bench;
   logic clk_sys = 1'b0, rstn = 1'b0;
   logic vb = 1'b0, bat = 1'b1, ov = 1'b0, bad = 1'b0;
   logic term = 1'b0, rech = 1'b0, bov = 1'b0, cen = 1'b1;
   logic chg, done, rreq, bovs, sfx, topact, dtk;
   logic wr = 1'b0, wd = 1'b0, svc = 1'b0;
   logic det_done, por, rdy, drv, sw, mon, bias, sink, dst, conv, dreq, hiz;
   logic [4:0] det_ilim, ilim;
   logic [2:0] fails;
   logic wdx;
   int n_fail = 0, total_checks = 0, n;
   always #5 clk_sys = ~clk_sys;
   cpus_sequencer #(.MS_CYCLES(10), .SAFETY_MS(300), .TOPOFF_MS(10), .WDT_MS(10))
   cpus_sequencer_i (.clk_sys(clk_sys), .rstn(rstn), .vbus_above_uvlo(vb),
      .bat_above_uvlo(bat), .vbus_over_volt(ov), .vbus_below_bad_src(bad),
      .chg_below_term(term), .bat_below_rech(rech), .bat_over_volt(bov),
      .det_done(det_done), .det_ilim(det_ilim), .charge_en(cen),
      .disconnect_wr(wr), .disconnect_wdata(wd), .host_service(svc),
      .charge_time_limit_sel(2'h2), .finish_charge_time_sel(2'h2),
      .watchdog_sel(2'h3), .por_rst(por), .i2c_ready(rdy),
      .battery_switch_drv_en(drv), .battery_switch(sw), .discharge_monitor_en(mon),
      .internal_bias_regulator(bias), .bad_src_sink_en(sink), .det_start(dst),
      .converter_en(conv), .input_current_limit_field(ilim),
      .input_disconnect_request(dreq), .hiz(hiz), .fail_count(fails),
      .charging(chg), .charge_done(done), .recharge_req(rreq), .bat_ovp_stop(bovs),
      .safety_expired(sfx), .topoff_active(topact), .watchdog_expired(wdx), .dig_tick(dtk));
   cpus_far_side cpus_far_side_i (.clk_sys(clk_sys), .rstn(rstn), .det_start(dst),
      .bad_src_sink_en(sink), .det_done(det_done), .det_ilim(det_ilim));
   // ****************
   // tasks
   // ****************
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk
   function logic sig(input int w);
      case (w)
         0: return por;
         1: return dst;
         2: return bias;
         3: return ~conv;
         4: return sink;
         5: return hiz;
         default: return wdx;
      endcase
   endfunction : sig
   // bounded wait, sampled at the falling edge where outputs are settled
   task wait_on(input int w, input int lim);
      n = 0;
      while (sig(w) !== 1'b1 && n < lim)
      begin
         @(negedge clk_sys);
         n++;
      end
   endtask : wait_on
   task host_wr(input logic v);
      @(negedge clk_sys);
      wr = 1'b1;
      wd = v;
      @(negedge clk_sys);
      wr = 1'b0;
   endtask : host_wr
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   // ****************
   // tests
   // ****************
   initial
   begin
      // about 10500 clocks expected; long margin
      #600000;
      n_fail++;
      conclude();
   end
   initial
   begin
      repeat (3) @(negedge clk_sys);
      rstn = 1'b1;
      wait_on(0, 10);
      chk("por", n < 10, 1);
      repeat (3) @(negedge clk_sys);
      chk("ready", rdy, 1);
      chk("ilim", ilim, 5'h04);
      chk("drv", drv, 1);
      chk("switch", sw, 1);
      chk("bias", bias, 0);
      chk("monitor", mon, 1);
      $display("battery only test done");
      svc = 1'b1;
      @(negedge clk_sys);
      svc = 1'b0;
      vb = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("sink", sink, 1);
      wait_on(1, 400);
      chk("qual", n >= 290 && n <= 320, 1);
      chk("conv", conv, 0);
      wait_on(2, 2400);
      chk("biaswait", n >= 2190 && n <= 2230, 1);
      chk("ilim", ilim, 5'h0B);
      repeat (2) @(negedge clk_sys);
      chk("conv", conv, 1);
      $display("attach test done");
      svc = 1'b1;
      @(negedge clk_sys);
      svc = 1'b0;
      wait_on(6, 200);
      chk("wdt", n >= 95 && n <= 110, 1);
      chk("charging", chg, 1);
      bov = 1'b1;
      repeat (50) @(negedge clk_sys);
      chk("ovpearly", bovs, 0);
      repeat (60) @(negedge clk_sys);
      chk("ovpstop", bovs, 1);
      chk("ovpchg", chg, 0);
      bov = 1'b0;
      term = 1'b1;
      n = 0;
      repeat (660)
      begin
         @(negedge clk_sys);
         n += dtk;
      end
      chk("digrate", n, 10);
      repeat (1830) @(negedge clk_sys);
      chk("termearly", done, 0);
      repeat (20) @(negedge clk_sys);
      chk("term", done, 1);
      chk("topoff", topact, 1);
      repeat (100) @(negedge clk_sys);
      chk("topend", topact, 0);
      chk("topchg", chg, 0);
      term = 1'b0;
      rech = 1'b1;
      repeat (2490) @(negedge clk_sys);
      chk("rechearly", rreq, 0);
      repeat (20) @(negedge clk_sys);
      chk("rech", rreq, 1);
      chk("rechdone", done, 0);
      chk("safetyearly", sfx, 0);
      repeat (200) @(negedge clk_sys);
      chk("safety", sfx, 1);
      chk("safetychg", chg, 0);
      $display("charge test done");
      ov = 1'b1;
      wait_on(3, 10);
      chk("ovoff", n <= 4, 1);
      ov = 1'b0;
      wait_on(4, 10);
      chk("ovretry", sink, 1);
      $display("overvoltage test done");
      bad = 1'b1;
      wait_on(5, 2600);
      chk("badtime", n >= 2000, 1);
      chk("hiz", hiz, 1);
      chk("fails", fails, 3'h7);
      chk("bias", bias, 0);
      bad = 1'b0;
      host_wr(1'b1);
      host_wr(1'b0);
      repeat (2) @(negedge clk_sys);
      chk("hizexit", hiz, 0);
      chk("fails", fails, 3'h0);
      chk("sink", sink, 1);
      host_wr(1'b1);
      vb = 1'b0;
      repeat (5) @(negedge clk_sys);
      vb = 1'b1;
      repeat (5) @(negedge clk_sys);
      chk("attachclr", dreq, 0);
      $display("bad source test done");
      conclude();
   end
endmodule : charger_power_up_sequencer_bench
`default_nettype wire

// ==== verification/cpus_far_side.sv ====
// adapter side model: answers a detection request with a fixed limit
// assumes det_start and bad_src_sink_en from the sequencer, one clock
`timescale 1ns/1ns
`default_nettype none
module cpus_far_side #(
   parameter int DELAY = 5,
   parameter logic [4:0] ILIM = 5'h0B
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic det_start,
   input wire logic bad_src_sink_en,
   output logic det_done,
   output logic [4:0] det_ilim
);
   int cnt;
   // result held while valid; otherwise inverted to avoid a lucky match
   assign det_ilim = det_done ? ILIM : ~ILIM;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt <= 0;
         det_done <= 1'b0;
      end
      else if (bad_src_sink_en)
      begin
         // a new qualification drops the old result
         cnt <= 0;
         det_done <= 1'b0;
      end
      else if (det_start && cnt < DELAY)
         cnt <= cnt + 1;
      else if (det_start)
         det_done <= 1'b1;
   end
endmodule : cpus_far_side
`default_nettype wire
